// file: hdl/mdr_device.sv
// Purpose: device end, register bank behind the management link
// Assumes: link clock runs freely from the host
// Notes:   all bank logic lives on the link clock
`timescale 1ns/1ps
module mdr_device
	import mdr_pkg::*;
#(
	parameter int EXT_N = EXT_DEPTH
) (
	// link
	mdr_mdio_if.dev               lnk,
	// reset and straps
	input  wire logic             i_rst_n,
	input  wire logic [3:0]       i_port_address_straps,
	// live conditions
	input  wire logic             i_lat_window,
	input  wire logic             i_comma_hi,
	input  wire logic             i_comma_lo,
	input  wire logic [1:0]       i_fault_cond,
	input  wire logic [1:0]       i_event_cond,
	// controls out
	output logic                  o_global_rst,
	output logic [1:0]            o_chan_rst,
	output logic [14:0]           o_global_ctrl,
	output logic [1:0][15:0]      o_chan_ctrl
);
	// =====================================================
	// state
	typedef struct packed {
		mdr_dev_state_t                    state;
		logic [5:0]                        bcnt;
		logic [15:0]                       shift;
		logic [1:0]                        op;
		logic [4:0]                        phy;
		logic [4:0]                        regad;
		logic                              hit;
		logic [15:0]                       rsh;
		logic                              dout;
		logic                              oe_n;
		logic [14:0]                       glob;
		logic [1:0][CHAN_REGS-1:0][15:0]   chreg;
		logic [15:0]                       lat_ctrl;
		logic [CNT_W-1:0]                  cnt;
		logic [15:0]                       shadow;
		logic                              cm_hi;
		logic                              cm_lo;
		logic                              cval;
		logic                              win_d;
		logic [1:0]                        latched_low_bit;
		logic [1:0]                        latched_high_bit;
		logic [15:0]                       ext_addr;
		logic [EXT_N-1:0][15:0]            ext;
		logic                              grst;
		logic [1:0]                        crst;
	} mdr_dev_t;

	mdr_dev_t    r_reg;
	mdr_dev_t    r_next;
	mdr_dev_t    r_rst;
	logic [1:0]  rst_sync_reg;
	logic [9:0]  in_m1_reg;
	logic [9:0]  in_m2_reg;
	logic        srst_n;
	logic [3:0]  straps_s;
	logic        win_s;
	logic        chi_s;
	logic        clo_s;
	logic [1:0]  fault_s;
	logic [1:0]  evt_s;

	// =====================================================
	// synchronisers on the link clock
	always_ff @(posedge lnk.mdc) begin
		rst_sync_reg <= {rst_sync_reg[0], i_rst_n};
		in_m1_reg    <= {i_port_address_straps, i_lat_window, i_comma_hi, i_comma_lo,
		                 i_fault_cond, i_event_cond[0]};
		in_m2_reg    <= in_m1_reg;
	end

	logic evt1_m1_reg;
	logic evt1_m2_reg;
	always_ff @(posedge lnk.mdc) begin
		evt1_m1_reg <= i_event_cond[1];
		evt1_m2_reg <= evt1_m1_reg;
	end

	assign srst_n   = rst_sync_reg[1];
	assign straps_s = in_m2_reg[9:6];
	assign win_s    = in_m2_reg[5];
	assign chi_s    = in_m2_reg[4];
	assign clo_s    = in_m2_reg[3];
	assign fault_s  = in_m2_reg[2:1];
	assign evt_s    = {evt1_m2_reg, in_m2_reg[0]};

	always_comb begin
		r_rst        = '0;
		r_rst.state  = S_HUNT;
		r_rst.oe_n   = 1'b1;
		r_rst.dout   = 1'b1;
		r_rst.latched_low_bit = 2'b11;
	end

	// =====================================================
	// helpers
	function automatic logic [3:0] chan_idx(input logic [4:0] ra);
		chan_idx = (ra == REG_CHAN_EXTRA) ? 4'(CHAN_REGS - 1) : 4'(ra - REG_CHAN_FIRST);
	endfunction

	function automatic logic is_chan(input logic [4:0] ra);
		is_chan = ((ra >= REG_CHAN_FIRST) && (ra <= REG_CHAN_LAST)) || (ra == REG_CHAN_EXTRA);
	endfunction

	function automatic logic ext_ok(input logic [15:0] a);
		ext_ok = (a >= EXT_BASE) && ((a - EXT_BASE) < 16'(EXT_N));
	endfunction

	// =====================================================
	// next state
	always_comb begin
		logic        ch;
		logic        inc_now;
		logic        end_now;
		logic [11:0] hdr;
		logic [15:0] wd;
		logic [15:0] rd;
		ch      = 1'b0;
		hdr     = '0;
		wd      = '0;
		rd      = '0;
		r_next  = r_reg;
		r_next.grst = 1'b0;
		r_next.crst = 2'b00;
		// live condition tracking
		inc_now = r_reg.lat_ctrl[LAT_RUN_BIT] && win_s && (r_reg.cnt != '1);
		end_now = r_reg.win_d && !win_s;
		r_next.win_d = win_s;
		if (inc_now) begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end
		if (end_now) begin
			r_next.cval = 1'b1;
		end
		if (chi_s) begin
			r_next.cm_hi = 1'b1;
		end
		if (clo_s) begin
			r_next.cm_lo = 1'b1;
		end
		r_next.latched_low_bit  = r_reg.latched_low_bit & ~fault_s;
		r_next.latched_high_bit = r_reg.latched_high_bit | evt_s;
		case (r_reg.state)
			S_HUNT: begin
				r_next.oe_n = 1'b1;
				if (lnk.mdio) begin
					r_next.bcnt = (r_reg.bcnt == PREAMBLE_BITS) ? r_reg.bcnt : r_reg.bcnt + 1'b1;
				end else begin
					r_next.bcnt  = '0;
					r_next.state = (r_reg.bcnt == PREAMBLE_BITS) ? S_HDR : S_HUNT;
				end
			end
			S_HDR: begin
				r_next.shift = {r_reg.shift[14:0], lnk.mdio};
				r_next.bcnt  = r_reg.bcnt + 1'b1;
				hdr          = {r_reg.shift[10:0], lnk.mdio};
				if (r_reg.bcnt == '0 && !lnk.mdio) begin
					r_next.state = S_HUNT;
					r_next.bcnt  = '0;
				end else if (r_reg.bcnt == HDR_BITS) begin
					r_next.op    = hdr[11:10];
					r_next.phy   = hdr[9:5];
					r_next.regad = hdr[4:0];
					r_next.hit   = (hdr[9:6] == straps_s);
					r_next.bcnt  = '0;
					ch           = hdr[5];
					r_next.state = (hdr[11:10] == OP_READ) ? S_RD :
					               (hdr[11:10] == OP_WRITE) ? S_WR : S_HUNT;
					if (hdr[11:10] == OP_READ && hdr[9:6] == straps_s) begin
						case (hdr[4:0])
							REG_GLOBAL:    rd = {1'b0, r_reg.glob};
							REG_CHAN_STATUS: begin
								rd[ST_LATCH_LOW]  = r_reg.latched_low_bit[ch] & ~fault_s[ch];
								rd[ST_LATCH_HIGH] = r_reg.latched_high_bit[ch] | evt_s[ch];
								r_next.latched_low_bit[ch]  = ~fault_s[ch];
								r_next.latched_high_bit[ch] = evt_s[ch];
							end
							REG_LAT_CTRL:  rd = r_reg.lat_ctrl;
							REG_LAT_UPPER: begin
								rd[UP_COMMA_HI] = r_reg.cm_hi;
								rd[UP_COMMA_LO] = r_reg.cm_lo;
								rd[UP_VALID]    = r_reg.cval;
								rd[3:0]         = r_reg.cnt[CNT_W-1:16];
								r_next.shadow   = r_reg.cnt[15:0];
							end
							REG_LAT_LOWER: begin
								rd           = r_reg.shadow;
								r_next.cnt   = inc_now ? CNT_W'(1) : '0;
								r_next.cm_hi = chi_s;
								r_next.cm_lo = clo_s;
								r_next.cval  = end_now;
							end
							REG_EXT_ADDR:  rd = r_reg.ext_addr;
							REG_EXT_DATA:  rd = ext_ok(r_reg.ext_addr) ?
							                    r_reg.ext[2'(r_reg.ext_addr - EXT_BASE)] : '0;
							default: begin
								if (is_chan(hdr[4:0])) begin
									rd = r_reg.chreg[ch][chan_idx(hdr[4:0])];
									if (hdr[4:0] == REG_CHAN_FIRST) begin
										rd[RST_BIT] = 1'b0;
									end
								end else begin
									rd = '0;
								end
							end
						endcase
					end
					r_next.rsh = rd;
				end
			end
			S_RD: begin
				// turnaround first half stays released so the host can let go
				r_next.bcnt = r_reg.bcnt + 1'b1;
				r_next.oe_n = !r_reg.hit || (r_reg.bcnt == RD_TAIL);
				if (r_reg.bcnt == '0) begin
					r_next.dout = 1'b0;
				end else begin
					r_next.dout = r_reg.rsh[15];
					r_next.rsh  = {r_reg.rsh[14:0], 1'b0};
				end
				if (r_reg.bcnt == RD_TAIL) begin
					r_next.state = S_HUNT;
					r_next.bcnt  = '0;
					r_next.dout  = 1'b1;
				end
			end
			S_WR: begin
				r_next.shift = {r_reg.shift[14:0], lnk.mdio};
				r_next.bcnt  = r_reg.bcnt + 1'b1;
				wd           = {r_reg.shift[14:0], lnk.mdio};
				ch           = r_reg.phy[0];
				if (r_reg.bcnt == RD_TAIL) begin
					r_next.state = S_HUNT;
					r_next.bcnt  = '0;
					if (r_reg.hit) begin
						case (r_reg.regad)
							REG_GLOBAL: begin
								r_next.glob = wd[14:0];
								r_next.grst = wd[RST_BIT];
							end
							REG_CHAN_STATUS: ;
							REG_LAT_CTRL: r_next.lat_ctrl = wd;
							REG_EXT_ADDR: r_next.ext_addr = wd;
							REG_EXT_DATA: begin
								if (ext_ok(r_reg.ext_addr)) begin
									r_next.ext[2'(r_reg.ext_addr - EXT_BASE)] = wd;
								end
							end
							default: begin
								if (is_chan(r_reg.regad)) begin
									r_next.chreg[ch][chan_idx(r_reg.regad)] = wd;
									if (r_reg.regad == REG_CHAN_FIRST) begin
										r_next.chreg[ch][0][RST_BIT] = 1'b0;
										r_next.crst[ch] = wd[RST_BIT];
									end
								end
							end
						endcase
					end
				end
			end
			default: begin
				r_next = r_rst;
			end
		endcase
	end

	always_ff @(posedge lnk.mdc) begin
		if (!srst_n) begin
			r_reg <= r_rst;
		end else begin
			r_reg <= r_next;
		end
	end

	// =====================================================
	// outputs
	assign lnk.dev_mdio_o    = r_reg.dout;
	assign lnk.dev_mdio_oe_n = r_reg.oe_n;
	assign o_global_rst      = r_reg.grst;
	assign o_chan_rst        = r_reg.crst;
	assign o_global_ctrl     = r_reg.glob;
	assign o_chan_ctrl       = {r_reg.chreg[1][0], r_reg.chreg[0][0]};
endmodule

// file: hdl/mdr_host.sv
// Purpose: host end, frames one register access per request
// Assumes: request only while not busy
// Notes:   link clock is divided down and runs freely
`timescale 1ns/1ps
module mdr_host
	import mdr_pkg::*;
#(
	parameter int HALF = MDC_HALF
) (
	// clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst_n,
	// link
	mdr_mdio_if.host          lnk,
	// requests
	input  wire logic         i_req,
	input  wire logic         i_write,
	input  wire logic [4:0]   i_phy,
	input  wire logic [4:0]   i_regad,
	input  wire logic [15:0]  i_wdata,
	// answers
	output logic              o_busy,
	output logic              o_done,
	output logic [15:0]       o_rdata
);
	// =====================================================
	// state
	typedef struct packed {
		mdr_host_state_t  state;
		logic [7:0]       div;
		logic             mdc;
		logic [5:0]       bit_idx;
		logic [63:0]      frame;
		logic             rd;
		logic             mo;
		logic             oe_n;
		logic [15:0]      rdata;
		logic             done;
		logic             busy;
	} mdr_host_t;

	mdr_host_t  r_reg;
	mdr_host_t  r_next;
	logic       mdio_m1_reg;
	logic       mdio_m2_reg;

	// line comes back from the far end, two flops before use
	always_ff @(posedge i_mclk) begin
		mdio_m1_reg <= lnk.mdio;
		mdio_m2_reg <= mdio_m1_reg;
	end

	// =====================================================
	// next state
	always_comb begin
		logic edge_now;
		r_next      = r_reg;
		r_next.done = 1'b0;
		edge_now    = (r_reg.div == 8'(HALF - 1));
		r_next.div  = edge_now ? '0 : r_reg.div + 1'b1;
		if (edge_now) begin
			r_next.mdc = !r_reg.mdc;
		end
		case (r_reg.state)
			H_IDLE: begin
				if (i_req) begin
					// channel choice is simply the PHY address LSB the user gives
					r_next.frame = {{32{1'b1}}, 2'b01, i_write ? OP_WRITE : OP_READ,
					                i_phy, i_regad, 2'b10, i_wdata};
					r_next.rd      = !i_write;
					r_next.bit_idx = '0;
					r_next.busy    = 1'b1;
					r_next.state   = H_RUN;
				end
			end
			H_RUN: begin
				// drive on falling, sample on rising
				if (edge_now && r_reg.mdc) begin
					r_next.mo   = r_reg.frame[63];
					r_next.oe_n = r_reg.rd && (r_reg.bit_idx >= TA_FIRST);
				end
				if (edge_now && !r_reg.mdc && !r_reg.oe_n || edge_now && !r_reg.mdc && r_reg.rd
				    && r_reg.bit_idx >= TA_FIRST) begin
					r_next.frame   = {r_reg.frame[62:0], 1'b0};
					r_next.bit_idx = r_reg.bit_idx + 1'b1;
					if (r_reg.rd && r_reg.bit_idx >= DATA_FIRST) begin
						r_next.rdata = {r_reg.rdata[14:0], mdio_m2_reg};
					end
					if (r_reg.bit_idx == FRAME_LAST) begin
						r_next.state = H_DONE;
					end
				end
			end
			H_DONE: begin
				if (edge_now && r_reg.mdc) begin
					r_next.oe_n  = 1'b1;
					r_next.mo    = 1'b1;
					r_next.busy  = 1'b0;
					r_next.done  = 1'b1;
					r_next.state = H_IDLE;
				end
			end
			default: begin
				r_next.state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			r_reg       <= '0;
			r_reg.state <= H_IDLE;
			r_reg.mo    <= 1'b1;
			r_reg.oe_n  <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// =====================================================
	// outputs
	assign lnk.mdc            = r_reg.mdc;
	assign lnk.host_mdio_o    = r_reg.mo;
	assign lnk.host_mdio_oe_n = r_reg.oe_n;
	assign o_busy             = r_reg.busy;
	assign o_done             = r_reg.done;
	assign o_rdata            = r_reg.rdata;
endmodule

// file: hdl/mdr_mdio_if.sv
// Purpose: management link between host and device ends
// Assumes: open-drain style line with pull-up when nobody drives
// Notes:   enables are active low
`timescale 1ns/1ps
interface mdr_mdio_if;
	logic mdc;
	logic host_mdio_o;
	logic host_mdio_oe_n;
	logic dev_mdio_o;
	logic dev_mdio_oe_n;
	logic mdio;

	// resolved line, pull-up when idle
	assign mdio = !host_mdio_oe_n ? host_mdio_o : (!dev_mdio_oe_n ? dev_mdio_o : 1'b1);

	modport host (output mdc, output host_mdio_o, output host_mdio_oe_n, input mdio);
	modport dev  (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe_n);
endinterface

// file: hdl/mdr_pkg.sv
// Purpose: shared constants for the dual-channel management register link
// Assumes: clause 22 framing, two channels chosen by the low PHY address bit
// Notes:   register map, frame layout and link timing
// How it works
// - per-channel copies of 0x01-0x0C and 0x14
// - PHY address LSB 0 selects first channel
// - PHY address LSB 1 selects second channel
// - reset bits clear themselves next link cycle
// - host reads 0x11 before 0x12
// - reading 0x12 zeroes the 20-bit counter
// - reading 0x12 clears comma and valid flags
// - latched-low bit reads low on any occurrence
// - latched-high bit reads high on any occurrence
// - host rereads an active latched bit
// - clear-on-read counters zero right after read
// - ignore bad or read-only writes, invalid reads zero
// - answer only when PHY address matches straps
// - extended space through registers 30 and 31
package mdr_pkg;
	// =====================================================
	// register map
	localparam logic [4:0]  REG_GLOBAL      = 5'h00;
	localparam logic [4:0]  REG_CHAN_FIRST  = 5'h01;
	localparam logic [4:0]  REG_CHAN_LAST   = 5'h0C;
	localparam logic [4:0]  REG_CHAN_STATUS = 5'h0B;
	localparam logic [4:0]  REG_CHAN_EXTRA  = 5'h14;
	localparam logic [4:0]  REG_LAT_CTRL    = 5'h10;
	localparam logic [4:0]  REG_LAT_UPPER   = 5'h11;
	localparam logic [4:0]  REG_LAT_LOWER   = 5'h12;
	localparam logic [4:0]  REG_EXT_ADDR    = 5'h1E;
	localparam logic [4:0]  REG_EXT_DATA    = 5'h1F;
	localparam logic [15:0] EXT_BASE        = 16'h8000;
	localparam int          CHAN_REGS       = 13;
	localparam int          EXT_DEPTH       = 4;
	// =====================================================
	// field positions
	localparam int          RST_BIT         = 15;
	localparam int          LAT_RUN_BIT     = 0;
	localparam int          UP_COMMA_HI     = 15;
	localparam int          UP_COMMA_LO     = 14;
	localparam int          UP_VALID        = 4;
	localparam int          ST_LATCH_LOW    = 0;
	localparam int          ST_LATCH_HIGH   = 1;
	localparam int          CNT_W           = 20;
	// =====================================================
	// frame layout and timing
	localparam logic [1:0]  OP_WRITE        = 2'b01;
	localparam logic [1:0]  OP_READ         = 2'b10;
	localparam logic [5:0]  PREAMBLE_BITS   = 6'h20;
	localparam logic [5:0]  HDR_BITS        = 6'h0C;
	localparam logic [5:0]  RD_TAIL         = 6'h11;
	localparam logic [5:0]  FRAME_LAST      = 6'h3F;
	localparam logic [5:0]  TA_FIRST        = 6'h2E;
	localparam logic [5:0]  DATA_FIRST      = 6'h30;
	localparam int          MDC_PERIOD_NS   = 80;
	localparam int          MCLK_PERIOD_NS  = 10;
	localparam int          MDC_HALF        = MDC_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	// =====================================================
	// state codes
	typedef enum logic [1:0] {
		S_HUNT = 2'b00,
		S_HDR  = 2'b01,
		S_RD   = 2'b11,
		S_WR   = 2'b10
	} mdr_dev_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_RUN  = 2'b01,
		H_DONE = 2'b11
	} mdr_host_state_t;
endpackage

// file: sim/mdr_monitor.sv
// Purpose: wire checks on the management link between both ends
// Assumes: all sampling on link clock rising edges
// Notes:   takes the interface signals as plain inputs
`timescale 1ns/1ps
module mdr_monitor
	import mdr_pkg::*;
(
	// link clock and device reset
	input  wire logic mdc,
	input  wire logic i_rst_n,
	// link wires
	input  wire logic host_mdio_o,
	input  wire logic host_mdio_oe_n,
	input  wire logic dev_mdio_o,
	input  wire logic dev_mdio_oe_n,
	input  wire logic mdio
);
	// =====================================================
	// helpers: bit index of the host's frame, length of the device's answer
	logic [6:0] hcnt_reg;
	logic [4:0] dcnt_reg;
	logic [1:0] op_reg;

	always_ff @(posedge mdc) begin
		hcnt_reg <= (!i_rst_n || host_mdio_oe_n) ? 7'h00 : hcnt_reg + 7'h01;
		dcnt_reg <= (!i_rst_n || dev_mdio_oe_n) ? 5'h00 : dcnt_reg + 5'h01;
		op_reg   <= !i_rst_n ? 2'h0 :
			(hcnt_reg == 7'h22 || hcnt_reg == 7'h23) ? {op_reg[0], host_mdio_o} : op_reg;
	end

	// =====================================================
	// assertions
	default clocking cb @(posedge mdc); endclocking
	default disable iff (!i_rst_n);

	a_line_single: assert property (host_mdio_oe_n || dev_mdio_oe_n)
		else $error("both ends drive the line");
	a_answer_release: assert property ($fell(dev_mdio_oe_n) |-> ##17 dev_mdio_oe_n)
		else $error("device holds the line too long");
	a_preamble_ones: assert property ((!host_mdio_oe_n && hcnt_reg < 7'h20) |-> host_mdio_o)
		else $error("preamble bit low");
	a_start_bits: assert property ((!host_mdio_oe_n && hcnt_reg == 7'h20) |->
		!host_mdio_o ##1 host_mdio_o)
		else $error("start pattern wrong");
	a_frame_length: assert property ($rose(host_mdio_oe_n) |->
		(hcnt_reg == 7'h2E || hcnt_reg == 7'h40))
		else $error("host frame length wrong");
	a_turnaround: assert property ($fell(dev_mdio_oe_n) |->
		$past(hcnt_reg) == 7'h2E && !dev_mdio_o)
		else $error("answer turnaround wrong");
	a_answer_hold: assert property ($fell(dev_mdio_oe_n) |-> !dev_mdio_oe_n [*8])
		else $error("answer released early");
	a_answer_length: assert property ($rose(dev_mdio_oe_n) |-> dcnt_reg == 5'h11)
		else $error("answer length wrong");
	a_answer_read: assert property ($fell(dev_mdio_oe_n) |-> op_reg == OP_READ)
		else $error("device answered a write");
endmodule

// file: sim/tb_top.sv
// Purpose: drives host requests and checks device register behaviour
// Assumes: straps at 4'hA, device released from reset after the host
// Notes:   latency count checked within a window since inputs resync
`timescale 1ns/1ps
module tb_top;
	import mdr_pkg::*;
	// =====================================================
	// signals
	localparam logic [4:0]  CH0  = {4'hA, 1'h0};
	localparam logic [4:0]  CH1  = {4'hA, 1'h1};
	localparam logic [4:0]  BAD  = {4'h5, 1'h0};
	localparam logic [15:0] FULL = 16'hFFFF;
	logic             mclk        = 1'b0;
	logic             rst_n       = 1'b0;
	logic             dev_rst_n   = 1'b0;
	logic             req         = 1'b0;
	logic             wr          = 1'b0;
	logic [4:0]       phy         = 5'h00;
	logic [4:0]       regad       = 5'h00;
	logic [15:0]      wdata       = 16'h0000;
	logic             lat_window  = 1'b0;
	logic             comma_hi    = 1'b0;
	logic             comma_lo    = 1'b0;
	logic [1:0]       fault_cond  = 2'h0;
	logic [1:0]       event_cond  = 2'h0;
	logic [2:0]       seen_rst    = 3'h0;
	logic             busy;
	logic             done;
	logic [15:0]      rdata;
	logic             global_rst;
	logic [1:0]       chan_rst;
	logic [14:0]      global_ctrl;
	logic [1:0][15:0] chan_ctrl;
	int               fail_count  = 0;
	int               checks      = 0;

	always #5 mclk = ~mclk;

	mdr_mdio_if i_mdr_mdio_if();
	mdr_host i_mdr_host (.i_mclk(mclk), .i_rst_n(rst_n), .lnk(i_mdr_mdio_if), .i_req(req),
		.i_write(wr), .i_phy(phy), .i_regad(regad), .i_wdata(wdata), .o_busy(busy),
		.o_done(done), .o_rdata(rdata));
	mdr_device i_mdr_device (.lnk(i_mdr_mdio_if), .i_rst_n(dev_rst_n),
		.i_port_address_straps(4'hA), .i_lat_window(lat_window), .i_comma_hi(comma_hi),
		.i_comma_lo(comma_lo), .i_fault_cond(fault_cond), .i_event_cond(event_cond),
		.o_global_rst(global_rst), .o_chan_rst(chan_rst), .o_global_ctrl(global_ctrl),
		.o_chan_ctrl(chan_ctrl));
	mdr_monitor i_mdr_monitor (.mdc(i_mdr_mdio_if.mdc), .i_rst_n(dev_rst_n),
		.host_mdio_o(i_mdr_mdio_if.host_mdio_o), .host_mdio_oe_n(i_mdr_mdio_if.host_mdio_oe_n),
		.dev_mdio_o(i_mdr_mdio_if.dev_mdio_o), .dev_mdio_oe_n(i_mdr_mdio_if.dev_mdio_oe_n),
		.mdio(i_mdr_mdio_if.mdio));

	// reset pulses are one link cycle long, so keep them sticky
	always @(posedge i_mdr_mdio_if.mdc) seen_rst <= seen_rst | {global_rst, chan_rst};

	// =====================================================
	// tasks
	task automatic report_and_stop();
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [4:0] p, input logic [4:0] r,
		input logic [15:0] d);
		int n;
		@(posedge mclk);
		req <= 1'b1;
		wr <= w;
		phy <= p;
		regad <= r;
		wdata <= d;
		@(posedge mclk);
		req <= 1'b0;
		@(posedge mclk);
		check({15'h0000, busy}, 16'h0001);
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 2000) begin
			fail_count++;
			report_and_stop();
		end
		check({15'h0000, busy}, 16'h0000);
	endtask

	task automatic rd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] m,
		input logic [15:0] e);
		acc(1'b0, p, r, 16'h0000);
		check(rdata & m, e);
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// =====================================================
	// sequence
	initial begin
		hold(12);
		rst_n <= 1'b1;
		hold(40);
		dev_rst_n <= 1'b1;
		hold(40);
		acc(1'b1, CH0, 5'h02, 16'h1234);
		acc(1'b1, CH1, 5'h02, 16'h5A5A);
		acc(1'b1, CH0, REG_CHAN_EXTRA, 16'hBEEF);
		acc(1'b1, CH1, REG_CHAN_EXTRA, 16'h0101);
		acc(1'b1, CH1, REG_LAT_CTRL, 16'h0001);
		rd(CH0, 5'h02, FULL, 16'h1234);
		rd(CH1, 5'h02, FULL, 16'h5A5A);
		rd(CH0, REG_CHAN_EXTRA, FULL, 16'hBEEF);
		rd(CH1, REG_CHAN_EXTRA, FULL, 16'h0101);
		rd(CH0, REG_LAT_CTRL, FULL, 16'h0001);
		acc(1'b1, CH1, REG_CHAN_FIRST, 16'h8005);
		hold(16);
		check(chan_ctrl[1], 16'h0005);
		check(chan_ctrl[0], 16'h0000);
		check({13'h0000, seen_rst}, 16'h0002);
		rd(CH1, REG_CHAN_FIRST, 16'h8000, 16'h0000);
		// refused accesses
		acc(1'b1, BAD, 5'h02, 16'hFFFF);
		rd(BAD, 5'h02, FULL, 16'hFFFF);
		rd(CH0, 5'h02, FULL, 16'h1234);
		acc(1'b1, CH0, 5'h15, 16'hFFFF);
		rd(CH0, 5'h15, FULL, 16'h0000);
		acc(1'b1, CH0, REG_LAT_LOWER, 16'hFFFF);
		rd(CH0, REG_LAT_UPPER, FULL, 16'h0000);
		rd(CH0, REG_LAT_LOWER, FULL, 16'h0000);
		// extended space, edge of the implemented depth
		acc(1'b1, CH0, REG_EXT_ADDR, EXT_BASE + 16'h0001);
		acc(1'b1, CH0, REG_EXT_DATA, 16'hCAFE);
		acc(1'b1, CH0, REG_EXT_ADDR, EXT_BASE);
		acc(1'b1, CH0, REG_EXT_DATA, 16'h1111);
		rd(CH0, REG_EXT_DATA, FULL, 16'h1111);
		acc(1'b1, CH0, REG_EXT_ADDR, EXT_BASE + 16'h0001);
		rd(CH0, REG_EXT_DATA, FULL, 16'hCAFE);
		acc(1'b1, CH0, REG_EXT_ADDR, EXT_BASE + 16'(EXT_DEPTH));
		acc(1'b1, CH0, REG_EXT_DATA, 16'h7777);
		rd(CH0, REG_EXT_DATA, FULL, 16'h0000);
		// latched status bits
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		fault_cond <= 2'h2;
		hold(64);
		fault_cond <= 2'h0;
		hold(64);
		rd(CH1, REG_CHAN_STATUS, 16'h0003, 16'h0000);
		rd(CH1, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		event_cond <= 2'h1;
		hold(64);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0003);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0003);
		event_cond <= 2'h0;
		hold(64);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0003);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		event_cond <= 2'h2;
		hold(64);
		event_cond <= 2'h0;
		hold(64);
		rd(CH0, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		rd(CH1, REG_CHAN_STATUS, 16'h0003, 16'h0003);
		rd(CH1, REG_CHAN_STATUS, 16'h0003, 16'h0001);
		// latency measurement and clear on read
		lat_window <= 1'b1;
		comma_hi <= 1'b1;
		comma_lo <= 1'b1;
		hold(400);
		lat_window <= 1'b0;
		comma_hi <= 1'b0;
		comma_lo <= 1'b0;
		hold(64);
		rd(CH0, REG_LAT_UPPER, 16'hC01F, 16'hC010);
		acc(1'b0, CH0, REG_LAT_LOWER, 16'h0000);
		check({15'h0000, rdata >= 16'h0030 && rdata <= 16'h0034}, 16'h0001);
		rd(CH0, REG_LAT_UPPER, 16'hC01F, 16'h0000);
		rd(CH0, REG_LAT_LOWER, FULL, 16'h0000);
		// global reset bit last, it may clear other state
		acc(1'b1, CH0, REG_GLOBAL, 16'h8003);
		hold(16);
		check({1'b0, global_ctrl}, 16'h0003);
		check({13'h0000, seen_rst}, 16'h0006);
		rd(CH0, REG_GLOBAL, 16'h8000, 16'h0000);
		report_and_stop();
	end
endmodule
